// ### design/spfr_bus_est.sv
// supply-bus current estimate compared against the limit threshold
`timescale 1ns/1ps
module spfr_bus_est (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] i_phase,
  input wire logic [15:0] v_phase,
  input wire logic [15:0] v_bus,
  input wire logic [15:0] limit_thr,
  output logic over
);
  logic [31:0] pwr_ff, nxt_pwr;
  logic [31:0] cap_ff, nxt_cap;
  logic over_ff, nxt_over;

  // estimate = i*vph/vbus; compared as i*vph > thr*vbus so no divider is needed
  always_comb begin
    nxt_pwr = i_phase * v_phase;
    nxt_cap = limit_thr * v_bus;
    nxt_over = pwr_ff > cap_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_ff <= 32'h0000_0000;
      cap_ff <= 32'h0000_0000;
      over_ff <= 1'b0;
    end else begin
      pwr_ff <= nxt_pwr;
      cap_ff <= nxt_cap;
      over_ff <= nxt_over;
    end
  end

  assign over = over_ff;
endmodule : spfr_bus_est

// ### design/spfr_pkg.sv
// shared constants for the speed pulse and fault response block
package spfr_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RETRY_TIME_US = 100;
  localparam int RETRY_CYCLES_DEF = (RETRY_TIME_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BUS_LIMIT = 8'h04;
  localparam logic [7:0] OFS_BEMF_THR = 8'h08;
  localparam logic [7:0] OFS_SPEED_REQ = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_STAT = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;
  localparam logic [7:0] OFS_CMD = 8'h1C;
  localparam logic [7:0] OFS_SPEED_REF = 8'h20;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_MODE_BIT = 2;
  localparam int CTRL_OVP_BIT = 3;
  localparam int CTRL_OCP_LSB = 4;
  localparam int CTRL_BLIM_BIT = 6;
  localparam int CMD_CLR_BIT = 0;

  // status bits and interrupt event bits
  localparam int ST_DRV_FAULT = 0;
  localparam int ST_BLIM = 1;
  localparam int ST_OVP = 2;
  localparam int ST_OCP = 3;
  localparam int EV_OCP = 0;
  localparam int EV_OVP = 1;
  localparam int EV_BLIM = 2;
  localparam int EV_LOCK = 3;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] BUS_LIMIT_RST = 16'hFFFF;
  localparam logic [15:0] BEMF_THR_RST = 16'h0000;
  localparam logic [15:0] SPEED_REQ_RST = 16'h0000;
  localparam logic [3:0] INT_MASK_RST = 4'h0;
  localparam logic [15:0] LIM_OPEN = 16'hFFFF;
  localparam logic [1:0] SEL_FOLLOW = 2'h0;
  localparam logic [1:0] SEL_HIGH = 2'h1;
  localparam logic [1:0] SEL_FIRST = 2'h2;
  localparam logic [1:0] OCP_LATCH = 2'h0;
  localparam logic [1:0] OCP_RETRY = 2'h1;
  localparam logic [1:0] OCP_REPORT = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OC_IDLE = 4'h1,
    OC_LATCH = 4'h2,
    OC_RETRY = 4'h4,
    OC_REPORT = 4'h8
  } spfr_oc_state_t;
endpackage : spfr_pkg

// ### design/spfr_retry_timer.sv
// one-shot timer for the automatic overcurrent retry
`timescale 1ns/1ps
module spfr_retry_timer #(
  parameter int RETRY_CYCLES = spfr_pkg::RETRY_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  output logic done
);
  logic [23:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;

  // count down from the retry length; done pulses once when it expires
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    if (start) begin
      nxt_cnt = 24'(RETRY_CYCLES);
    end else if (cnt_ff != 24'h00_0000) begin
      nxt_cnt = cnt_ff - 24'h00_0001;
      nxt_done = (cnt_ff == 24'h00_0001);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 24'h00_0000;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;
endmodule : spfr_retry_timer

// ### design/spfr_top.sv
// speed pulse output, bus current limit and fault response with AXI4-Lite registers
//
// What this block does
// - closed loop: pulse toggles with driving speed
// - motor lock holds pulse output high
// - select 00b: open loop follows driving frequency
// - select 01b: open loop holds output high
// - select 10b: follow first start-up, later high
// - limit enabled: clamp speed reference to a ceiling that steps down while over threshold
// - estimate bus current from phase and bus
// - report limit active in readable status
// - overvoltage enable: report, tri-state, auto-recover
// - overcurrent 00b: report, tri-state, latch until clear
// - overcurrent 01b: report, tri-state, retry later
// - overcurrent 10b: report only, bridge stays active
// - overcurrent 11b: no report, no action
// - pulse mode adds back-EMF window to drive window
`timescale 1ns/1ps
module spfr_top #(
  parameter int RETRY_CYCLES = spfr_pkg::RETRY_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic drive_active,
  input wire logic open_loop,
  input wire logic motor_lock,
  input wire logic drive_tick,
  input wire logic wake_event,
  input wire logic [15:0] backemf_level,
  input wire logic overvoltage,
  input wire logic overcurrent,
  input wire logic [15:0] phase_current,
  input wire logic [15:0] phase_voltage,
  input wire logic [15:0] bus_voltage,
  output logic speed_pulse_out,
  output logic fault_pin_n,
  output logic bridge_hiz,
  output logic [15:0] speed_ref,
  output logic irq
);
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [15:0] blim_ff, nxt_blim, bemf_ff, nxt_bemf, sreq_ff, nxt_sreq;
  logic [3:0] imask_ff, nxt_imask, istat_ff, nxt_istat;
  logic clr_ff, nxt_clr;
  logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
  logic [1:0] nxt_bresp, nxt_rresp;
  logic [31:0] nxt_rdata;
  logic wr_go, rd_go, wr_hit;
  logic [3:0] events, status;
  logic [15:0] speed_ref_ff;

  // byte-lane merge, used by the control, limit, threshold, request and mask registers
  function automatic logic [31:0] spfr_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : spfr_merge

  // write decoding, read mux and sticky flags; hardware set beats software clear
  always_comb begin
    wr_go = s_axi_awvalid && awready_ff && s_axi_wvalid && wready_ff;
    rd_go = s_axi_arvalid && arready_ff;
    nxt_awready = !awready_ff && !bvalid_ff && s_axi_awvalid && s_axi_wvalid;
    nxt_wready = nxt_awready;
    nxt_bvalid = bvalid_ff ? !s_axi_bready : wr_go;
    nxt_arready = !arready_ff && !rvalid_ff && s_axi_arvalid;
    nxt_rvalid = rvalid_ff ? !s_axi_rready : rd_go;
    nxt_ctrl = ctrl_ff;
    nxt_blim = blim_ff;
    nxt_bemf = bemf_ff;
    nxt_sreq = sreq_ff;
    nxt_imask = imask_ff;
    nxt_istat = istat_ff;
    nxt_clr = 1'b0;
    nxt_bresp = bresp_ff;
    wr_hit = 1'b1;
    if (wr_go) begin
      case (s_axi_awaddr)
        spfr_pkg::OFS_CTRL: nxt_ctrl = spfr_merge(ctrl_ff, s_axi_wdata, s_axi_wstrb) & 32'h7F;
        spfr_pkg::OFS_BUS_LIMIT:
          nxt_blim = 16'(spfr_merge({16'h0000, blim_ff}, s_axi_wdata, s_axi_wstrb));
        spfr_pkg::OFS_BEMF_THR:
          nxt_bemf = 16'(spfr_merge({16'h0000, bemf_ff}, s_axi_wdata, s_axi_wstrb));
        spfr_pkg::OFS_SPEED_REQ:
          nxt_sreq = 16'(spfr_merge({16'h0000, sreq_ff}, s_axi_wdata, s_axi_wstrb));
        spfr_pkg::OFS_INT_MASK:
          nxt_imask = 4'(spfr_merge({28'h0, imask_ff}, s_axi_wdata, s_axi_wstrb));
        spfr_pkg::OFS_INT_STAT: nxt_istat = istat_ff & ~(s_axi_wdata[3:0] & {4{s_axi_wstrb[0]}});
        spfr_pkg::OFS_CMD: nxt_clr = s_axi_wdata[spfr_pkg::CMD_CLR_BIT] && s_axi_wstrb[0];
        spfr_pkg::OFS_STATUS, spfr_pkg::OFS_SPEED_REF: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
      nxt_bresp = wr_hit ? spfr_pkg::RESP_OKAY : spfr_pkg::RESP_SLVERR;
    end
    nxt_istat = nxt_istat | events;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rd_go) begin
      nxt_rresp = spfr_pkg::RESP_OKAY;
      case (s_axi_araddr)
        spfr_pkg::OFS_CTRL: nxt_rdata = ctrl_ff;
        spfr_pkg::OFS_BUS_LIMIT: nxt_rdata = {16'h0000, blim_ff};
        spfr_pkg::OFS_BEMF_THR: nxt_rdata = {16'h0000, bemf_ff};
        spfr_pkg::OFS_SPEED_REQ: nxt_rdata = {16'h0000, sreq_ff};
        spfr_pkg::OFS_STATUS: nxt_rdata = {28'h0, status};
        spfr_pkg::OFS_INT_STAT: nxt_rdata = {28'h0, istat_ff};
        spfr_pkg::OFS_INT_MASK: nxt_rdata = {28'h0, imask_ff};
        spfr_pkg::OFS_CMD: nxt_rdata = 32'h0000_0000;
        spfr_pkg::OFS_SPEED_REF: nxt_rdata = {16'h0000, speed_ref_ff};
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = spfr_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= spfr_pkg::RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= spfr_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      ctrl_ff <= spfr_pkg::CTRL_RST;
      blim_ff <= spfr_pkg::BUS_LIMIT_RST;
      bemf_ff <= spfr_pkg::BEMF_THR_RST;
      sreq_ff <= spfr_pkg::SPEED_REQ_RST;
      imask_ff <= spfr_pkg::INT_MASK_RST;
      istat_ff <= 4'h0;
      clr_ff <= 1'b0;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      ctrl_ff <= nxt_ctrl;
      blim_ff <= nxt_blim;
      bemf_ff <= nxt_bemf;
      sreq_ff <= nxt_sreq;
      imask_ff <= nxt_imask;
      istat_ff <= nxt_istat;
      clr_ff <= nxt_clr;
    end
  end

  // ----------------------------------------------------------------
  // speed pulse output
  // ----------------------------------------------------------------
  logic [1:0] sel;
  logic pulse_ff, nxt_pulse, first_ff, nxt_first, ol_d_ff;
  logic lim_act_ff, nxt_lim_act;
  assign sel = ctrl_ff[spfr_pkg::CTRL_SEL_LSB +: 2];

  // lock first, then open-loop choice, then the running window
  always_comb begin
    nxt_pulse = 1'b0;
    nxt_first = first_ff;
    if (wake_event) begin
      nxt_first = 1'b1;
    end else if (ol_d_ff && !open_loop) begin
      nxt_first = 1'b0; // a start-up ends when open loop is left
    end
    if (motor_lock) begin
      nxt_pulse = 1'b1;
    end else if (open_loop) begin
      case (sel)
        spfr_pkg::SEL_FOLLOW: nxt_pulse = pulse_ff ^ drive_tick;
        spfr_pkg::SEL_HIGH: nxt_pulse = 1'b1;
        spfr_pkg::SEL_FIRST: nxt_pulse = first_ff ? (pulse_ff ^ drive_tick) : 1'b1;
        default: nxt_pulse = 1'b1;
      endcase
    end else if (drive_active || (ctrl_ff[spfr_pkg::CTRL_MODE_BIT] &&
                 backemf_level > bemf_ff)) begin
      nxt_pulse = pulse_ff ^ drive_tick;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_ff <= 1'b0;
      first_ff <= 1'b1;
      ol_d_ff <= 1'b0;
    end else begin
      pulse_ff <= nxt_pulse;
      first_ff <= nxt_first;
      ol_d_ff <= open_loop;
    end
  end

  // ----------------------------------------------------------------
  // bus current limit
  // ----------------------------------------------------------------
  logic bus_over;
  logic [15:0] lim_ff, nxt_lim, nxt_speed_ref;

  spfr_bus_est u_est (
    .aclk(aclk),
    .aresetn(aresetn),
    .i_phase(phase_current),
    .v_phase(phase_voltage),
    .v_bus(bus_voltage),
    .limit_thr(blim_ff),
    .over(bus_over)
  );

  // the ceiling walks down while over and back up after; slow but never oscillates hard
  always_comb begin
    nxt_lim = lim_ff;
    if (!ctrl_ff[spfr_pkg::CTRL_BLIM_BIT]) begin
      nxt_lim = spfr_pkg::LIM_OPEN;
    end else if (bus_over) begin
      nxt_lim = ((lim_ff < speed_ref_ff) ? lim_ff : speed_ref_ff);
      if (nxt_lim != 16'h0000) begin
        nxt_lim = nxt_lim - 16'h0001;
      end
    end else if (lim_ff != spfr_pkg::LIM_OPEN) begin
      nxt_lim = lim_ff + 16'h0001;
    end
    nxt_speed_ref = (sreq_ff < lim_ff) ? sreq_ff : lim_ff;
    nxt_lim_act = ctrl_ff[spfr_pkg::CTRL_BLIM_BIT] && (lim_ff < sreq_ff);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lim_ff <= spfr_pkg::LIM_OPEN;
      speed_ref_ff <= 16'h0000;
      lim_act_ff <= 1'b0;
    end else begin
      lim_ff <= nxt_lim;
      speed_ref_ff <= nxt_speed_ref;
      lim_act_ff <= nxt_lim_act;
    end
  end

  // ----------------------------------------------------------------
  // fault response
  // ----------------------------------------------------------------
  spfr_pkg::spfr_oc_state_t oc_ff, nxt_oc;
  logic [1:0] ocp_sel;
  logic ovp_act, retry_start, retry_done;
  logic fault_n_ff, nxt_fault_n, hiz_ff, nxt_hiz, irq_ff, nxt_irq;
  logic [3:0] prev_ff, cond;
  assign ocp_sel = ctrl_ff[spfr_pkg::CTRL_OCP_LSB +: 2];
  assign ovp_act = ctrl_ff[spfr_pkg::CTRL_OVP_BIT] && overvoltage;

  spfr_retry_timer #(.RETRY_CYCLES(RETRY_CYCLES)) u_retry (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(retry_start),
    .done(retry_done)
  );

  // overcurrent response state, outputs and interrupt events
  always_comb begin
    nxt_oc = oc_ff;
    case (oc_ff)
      spfr_pkg::OC_IDLE: begin
        if (overcurrent) begin
          case (ocp_sel)
            spfr_pkg::OCP_LATCH: nxt_oc = spfr_pkg::OC_LATCH;
            spfr_pkg::OCP_RETRY: nxt_oc = spfr_pkg::OC_RETRY;
            spfr_pkg::OCP_REPORT: nxt_oc = spfr_pkg::OC_REPORT;
            default: nxt_oc = spfr_pkg::OC_IDLE;
          endcase
        end
      end
      spfr_pkg::OC_LATCH: if (clr_ff) nxt_oc = spfr_pkg::OC_IDLE;
      spfr_pkg::OC_RETRY: if (retry_done) nxt_oc = spfr_pkg::OC_IDLE;
      spfr_pkg::OC_REPORT: if (!overcurrent) nxt_oc = spfr_pkg::OC_IDLE;
      default: nxt_oc = spfr_pkg::OC_IDLE;
    endcase
    retry_start = (oc_ff == spfr_pkg::OC_IDLE) && (nxt_oc == spfr_pkg::OC_RETRY);
    nxt_fault_n = (oc_ff == spfr_pkg::OC_IDLE) && !ovp_act;
    nxt_hiz = (oc_ff == spfr_pkg::OC_LATCH) || (oc_ff == spfr_pkg::OC_RETRY) || ovp_act;
    cond = {motor_lock, lim_act_ff, ovp_act, overcurrent && (ocp_sel != 2'h3)};
    events = cond & ~prev_ff;
    status = {oc_ff != spfr_pkg::OC_IDLE, ovp_act, lim_act_ff, !fault_n_ff};
    nxt_irq = |(istat_ff & imask_ff);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_ff <= spfr_pkg::OC_IDLE;
      fault_n_ff <= 1'b1;
      hiz_ff <= 1'b0;
      prev_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      oc_ff <= nxt_oc;
      fault_n_ff <= nxt_fault_n;
      hiz_ff <= nxt_hiz;
      prev_ff <= cond;
      irq_ff <= nxt_irq;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign speed_pulse_out = pulse_ff;
  assign fault_pin_n = fault_n_ff;
  assign bridge_hiz = hiz_ff;
  assign speed_ref = speed_ref_ff;
  assign irq = irq_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_latched;
    oc_ff == spfr_pkg::OC_LATCH && !clr_ff;
  endsequence

  a_lock_high: assert property (motor_lock |=> pulse_ff)
    else $error("pulse not high under lock");
  a_ol_forced: assert property (open_loop && !motor_lock && sel == 2'h1 |=> pulse_ff)
    else $error("open-loop pulse not forced high");
  a_cl_toggle: assert property (!motor_lock && !open_loop && drive_active && drive_tick
    |=> pulse_ff != $past(pulse_ff))
    else $error("closed-loop pulse missed a toggle");
  a_ol_follow: assert property (open_loop && !motor_lock && sel == 2'h0 && drive_tick
    |=> $changed(pulse_ff))
    else $error("open-loop pulse not following drive");
  a_sel_later: assert property (open_loop && !motor_lock && sel == 2'h2 && !first_ff
    |=> pulse_ff)
    else $error("later start-up pulse not high");
  a_ovp_quiet: assert property (oc_ff == spfr_pkg::OC_IDLE && !ovp_act
    |=> !hiz_ff && fault_n_ff)
    else $error("fault shown with no active fault");
  a_ocp_latch: assert property (s_latched ##1 oc_ff == spfr_pkg::OC_LATCH
    |-> !fault_n_ff && hiz_ff)
    else $error("latched overcurrent not held");
  a_ocp_retry: assert property (oc_ff == spfr_pkg::OC_RETRY |=> hiz_ff && !fault_n_ff)
    else $error("retry wait not tri-stated");
  a_ocp_report: assert property (oc_ff == spfr_pkg::OC_IDLE && overcurrent
    && ocp_sel == 2'h2 && !ovp_act ##1 !ovp_act |=> !fault_n_ff && !hiz_ff)
    else $error("report-only overcurrent wrong");
endmodule : spfr_top

// ### verification/spfr_ctrl_model.sv
// controller model that watches the speed pulse pin and the fault line
`timescale 1ns/1ps
module spfr_ctrl_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clr,
  input wire logic speed_pulse_out,
  input wire logic fault_pin_n,
  output logic [15:0] edges,
  output logic fault_seen
);
  logic last_ff;
  // counts both pulse edges; only the pin is visible to the controller
  always @(posedge aclk) begin
    if (!aresetn || clr) begin
      edges <= 16'h0000;
      fault_seen <= 1'h0;
    end else begin
      if (speed_pulse_out !== last_ff) edges <= edges + 16'h0001;
      if (fault_pin_n === 1'h0) fault_seen <= 1'h1;
    end
    last_ff <= speed_pulse_out;
  end
endmodule : spfr_ctrl_model

// ### verification/spfr_top_tb_top.sv
// self-checking bench for the speed pulse and fault response block
`timescale 1ns/1ps
module spfr_top_tb_top;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, br, r;
  logic drive_active = 1'h0, open_loop = 1'h0, motor_lock = 1'h0, drive_tick = 1'h0;
  logic wake_event = 1'h0, overvoltage = 1'h0, overcurrent = 1'h0, clr = 1'h0;
  logic [15:0] backemf_level = 16'h0, phase_current = 16'h0, phase_voltage = 16'h0;
  logic [15:0] bus_voltage = 16'hFFFF, speed_ref, edges;
  logic speed_pulse_out, fault_pin_n, bridge_hiz, irq, fault_seen;
  logic [31:0] d;
  int n_errors = 0, checks = 0, cyc = 0;
  typedef struct packed {
    logic [31:0] c;
    logic ol, lk, da;
    logic [15:0] be;
    logic [3:0] ne;
    logic lv;
  } spfr_row_t;
  // ctrl, open loop, lock, driving, back-EMF, pulse edges over 4 ticks, held level
  spfr_row_t rows [9] = '{
    '{32'h0, 1'h0, 1'h0, 1'h1, 16'h0, 4'h4, 1'h0},
    '{32'h0, 1'h0, 1'h1, 1'h1, 16'h0, 4'h0, 1'h1},
    '{32'h0, 1'h1, 1'h0, 1'h0, 16'h0, 4'h4, 1'h0},
    '{32'h1, 1'h1, 1'h0, 1'h0, 16'h0, 4'h0, 1'h1},
    '{32'h0, 1'h1, 1'h1, 1'h0, 16'h0, 4'h0, 1'h1},
    '{32'h0, 1'h0, 1'h0, 1'h0, 16'h20, 4'h0, 1'h0},
    '{32'h4, 1'h0, 1'h0, 1'h0, 16'h20, 4'h4, 1'h0},
    '{32'h4, 1'h0, 1'h0, 1'h0, 16'h5, 4'h0, 1'h0},
    '{32'h3, 1'h1, 1'h0, 1'h0, 16'h0, 4'h0, 1'h1}};

  // short retry count keeps the automatic recovery case brief
  spfr_top #(.RETRY_CYCLES(20)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .drive_active(drive_active),
    .open_loop(open_loop), .motor_lock(motor_lock), .drive_tick(drive_tick),
    .wake_event(wake_event), .backemf_level(backemf_level), .overvoltage(overvoltage),
    .overcurrent(overcurrent), .phase_current(phase_current), .phase_voltage(phase_voltage),
    .bus_voltage(bus_voltage), .speed_pulse_out(speed_pulse_out), .fault_pin_n(fault_pin_n),
    .bridge_hiz(bridge_hiz), .speed_ref(speed_ref), .irq(irq));

  spfr_ctrl_model u_ctrl (.aclk(aclk), .aresetn(aresetn), .clr(clr),
    .speed_pulse_out(speed_pulse_out), .fault_pin_n(fault_pin_n), .edges(edges),
    .fault_seen(fault_seen));

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    forever #5 aclk = ~aclk;
  end

  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge aclk);
  endtask : wait_clk

  // address and data offered together, each dropped when its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  // settle, clear the edge count, then send four driving ticks
  task automatic spin(input logic [3:0] ne);
    wait_clk(4);
    clr <= 1'h1;
    wait_clk(1);
    clr <= 1'h0;
    repeat (4) begin
      drive_tick <= 1'h1;
      wait_clk(1);
      drive_tick <= 1'h0;
      wait_clk(3);
    end
    chk("edges", edges, ne);
  endtask : spin

  // raise one fault, check the response, drop it, then clear
  task automatic fc(input logic [31:0] c, input logic ov, oc, hz, fl, hz2);
    wr(spfr_pkg::OFS_CTRL, c);
    overvoltage <= ov;
    overcurrent <= oc;
    wait_clk(4);
    chk("hiz", bridge_hiz, hz);
    if (oc) chk("fault", fault_pin_n, !fl);
    else begin
      rd(spfr_pkg::OFS_STATUS);
      chk("ovp", d[2], fl);
    end
    overvoltage <= 1'h0;
    overcurrent <= 1'h0;
    wait_clk(30);
    chk("hiz_after", bridge_hiz, hz2);
    wr(spfr_pkg::OFS_CMD, 32'h1);
    wait_clk(4);
    chk("cleared", {fault_pin_n, bridge_hiz}, 2'h2);
  endtask : fc

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    wait_clk(6);
    aresetn <= 1'h1;
    wait_clk(1);
    chk("rst_pins", {speed_pulse_out, fault_pin_n, bridge_hiz, irq}, 4'h4);
    rd(spfr_pkg::OFS_BUS_LIMIT);
    chk("lim_rst", d, 32'hFFFF);
    rd(8'h3C);
    chk("unmapped", d, 32'h0);
    chk("unmapped_r", r, spfr_pkg::RESP_SLVERR);
    wr(8'h3C, 32'h1);
    chk("unmapped_w", br, spfr_pkg::RESP_SLVERR);
    wr(spfr_pkg::OFS_STATUS, 32'hF);
    rd(spfr_pkg::OFS_STATUS);
    chk("status_ro", d, 32'h0);
    wr(spfr_pkg::OFS_BEMF_THR, 32'h10);
    // ordinary speed pulse cases from the table
    foreach (rows[i]) begin
      wr(spfr_pkg::OFS_CTRL, rows[i].c);
      open_loop <= rows[i].ol;
      motor_lock <= rows[i].lk;
      drive_active <= rows[i].da;
      backemf_level <= rows[i].be;
      spin(rows[i].ne);
      if (rows[i].ne == 4'h0) chk("level", speed_pulse_out, rows[i].lv);
    end
    // first start-up follows ticks, later ones hold high until a wake
    open_loop <= 1'h0;
    wr(spfr_pkg::OFS_CTRL, 32'h2);
    wake_event <= 1'h1;
    wait_clk(1);
    wake_event <= 1'h0;
    open_loop <= 1'h1;
    spin(4'h4);
    open_loop <= 1'h0;
    wait_clk(2);
    open_loop <= 1'h1;
    spin(4'h0);
    chk("level_sub", speed_pulse_out, 1'h1);
    open_loop <= 1'h0;
    // fault responses for every mode
    fc(32'h00, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
    fc(32'h10, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0);
    fc(32'h20, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
    fc(32'h30, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    fc(32'h00, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    fc(32'h08, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    chk("ctrl_saw", fault_seen, 1'h1);
    // bus current limit: large estimate against a small threshold
    wr(spfr_pkg::OFS_SPEED_REQ, 32'h20);
    wr(spfr_pkg::OFS_BUS_LIMIT, 32'h10);
    phase_current <= 16'h100;
    phase_voltage <= 16'h100;
    bus_voltage <= 16'h1;
    wait_clk(8);
    chk("ref_open", speed_ref, 16'h20);
    wr(spfr_pkg::OFS_CTRL, 32'h40);
    wait_clk(100);
    chk("ref_clamp", speed_ref < 16'h20, 1'h1);
    rd(spfr_pkg::OFS_STATUS);
    chk("lim_on", d[1], 1'h1);
    bus_voltage <= 16'hFFFF;
    // the ceiling climbs one step a cycle, so it needs time to pass the request
    wait_clk(40);
    rd(spfr_pkg::OFS_STATUS);
    chk("lim_off", d[1], 1'h0);
    // interrupt: events stick, mask gates the line, ones clear them
    rd(spfr_pkg::OFS_INT_STAT);
    chk("events", d, 32'hF);
    chk("irq_masked", irq, 1'h0);
    wr(spfr_pkg::OFS_INT_MASK, 32'h4);
    wait_clk(2);
    chk("irq_on", irq, 1'h1);
    wr(spfr_pkg::OFS_INT_STAT, 32'hF);
    wait_clk(2);
    rd(spfr_pkg::OFS_INT_STAT);
    chk("events_clr", d, 32'h0);
    chk("irq_off", irq, 1'h0);
    // mid-run reset returns pins and registers to their reset state
    aresetn <= 1'h0;
    wait_clk(6);
    aresetn <= 1'h1;
    wait_clk(1);
    chk("rst_again", {speed_ref, speed_pulse_out, fault_pin_n, bridge_hiz, irq}, 20'h4);
    rd(spfr_pkg::OFS_CTRL);
    chk("ctrl_rst", d, spfr_pkg::CTRL_RST);
    give_verdict();
  end
endmodule : spfr_top_tb_top
